// ==== icc_capture_ctrl.sv ====
// capture module command sequencer, top level
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
// Function
// - A one written to bit 8 turns the codec path on to capture one frame.
// - A codec request is ignored while a codec capture is still pending.
// - A one written to bit 2 starts a soft reset of the capture module.
// - A one written to bit 1 asks for the capture module to be disabled.
// - Enable and disable written together drops the disable request.
// - A one written to bit 0 asks for the capture module to be enabled.
module icc_capture_ctrl #(
  parameter logic [7:0] DIS_CYCLES = icc_pkg::ICC_DIS_CYCLES,
  parameter logic [7:0] SOFT_RESET_STATUS_FLAG_CYCLES = icc_pkg::ICC_SOFT_RESET_STATUS_FLAG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [icc_pkg::ICC_ADDR_W-1:0] reg_addr,
  input wire logic [icc_pkg::ICC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [icc_pkg::ICC_DATA_W-1:0] reg_rdata,
  input wire logic frame_done,
  output logic capture_enable,
  output logic codec_enable,
  output logic soft_reset
);
  import icc_pkg::*;

  icc_cmd_if cmd ();

  icc_state_e state_reg;
  icc_state_e state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic enabled_reg;
  logic enabled_next;
  logic disable_done_flag_reg;
  logic disable_done_flag_next;
  logic soft_reset_status_flag_reg;
  logic soft_reset_status_flag_next;
  logic codec_pending_flag_reg;
  logic codec_pending_flag_next;

  // ==================================================
  // register port
  icc_cmd_decode u_decode (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cmd(cmd)
  );

  // ==================================================
  // request qualification
  wire resetting = (state_reg == ICC_RESETTING);
  wire cnt_last = (cnt_reg == ICC_CNT_ZERO);
  wire take_cmd = !resetting && !cmd.req_soft_reset_status_flag;
  wire cdc_accept = take_cmd && cmd.req_cdc && !codec_pending_flag_reg;
  wire dis_start = take_cmd && cmd.req_dis;

  // ==================================================
  // sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    enabled_next = enabled_reg;
    disable_done_flag_next = disable_done_flag_reg;
    soft_reset_status_flag_next = soft_reset_status_flag_reg;
    case (state_reg)
      ICC_IDLE, ICC_DISABLING: begin
        if (state_reg == ICC_DISABLING && cnt_last) begin
          state_next = ICC_IDLE;
          enabled_next = 1'b0;
          disable_done_flag_next = 1'b1;
        end else if (state_reg == ICC_DISABLING) begin
          cnt_next = cnt_reg - ICC_CNT_ONE;
        end
        if (cmd.req_en) begin
          state_next = ICC_IDLE;
          enabled_next = 1'b1;
          disable_done_flag_next = 1'b0;
        end else if (dis_start && !enabled_reg) begin
          disable_done_flag_next = 1'b1;
        end else if (dis_start && state_reg == ICC_IDLE) begin
          state_next = ICC_DISABLING;
          cnt_next = DIS_CYCLES - ICC_CNT_ONE;
          disable_done_flag_next = 1'b0;
        end
      end
      ICC_RESETTING: begin
        if (cnt_last) begin
          state_next = ICC_IDLE;
          soft_reset_status_flag_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - ICC_CNT_ONE;
        end
      end
      default: begin
        state_next = ICC_IDLE;
      end
    endcase
    if (cmd.req_soft_reset_status_flag) begin
      state_next = ICC_RESETTING;
      cnt_next = SOFT_RESET_STATUS_FLAG_CYCLES - ICC_CNT_ONE;
      enabled_next = 1'b0;
      disable_done_flag_next = 1'b0;
      soft_reset_status_flag_next = 1'b1;
    end
  end

  // ==================================================
  // codec pending flag
  always_comb begin
    codec_pending_flag_next = codec_pending_flag_reg;
    if (frame_done || cmd.req_soft_reset_status_flag) begin
      codec_pending_flag_next = 1'b0;
    end
    if (cdc_accept) begin
      codec_pending_flag_next = 1'b1;
    end
  end

  // ==================================================
  // state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ICC_IDLE;
      cnt_reg <= ICC_CNT_ZERO;
      enabled_reg <= 1'b0;
      disable_done_flag_reg <= 1'b0;
      soft_reset_status_flag_reg <= 1'b0;
      codec_pending_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      enabled_reg <= enabled_next;
      disable_done_flag_reg <= disable_done_flag_next;
      soft_reset_status_flag_reg <= soft_reset_status_flag_next;
      codec_pending_flag_reg <= codec_pending_flag_next;
    end
  end

  // ==================================================
  // outputs and status
  assign capture_enable = enabled_reg;
  assign codec_enable = codec_pending_flag_reg;
  assign soft_reset = soft_reset_status_flag_reg;
  assign cmd.st_enabled = enabled_reg;
  assign cmd.st_disable_done_flag = disable_done_flag_reg;
  assign cmd.st_soft_reset_status_flag = soft_reset_status_flag_reg;
  assign cmd.st_codec_pending_flag = codec_pending_flag_reg;

  // ==================================================
  // checks
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  enable_take_a : assert property (
    (cmd.req_en && take_cmd) |=> (capture_enable && !disable_done_flag_reg))
    else $error("enable request not taken");
  disable_start_a : assert property (
    (dis_start && enabled_reg && state_reg == ICC_IDLE && !cmd.req_en)
    |=> (state_reg == ICC_DISABLING && capture_enable))
    else $error("disable did not start");
  disable_end_a : assert property (
    (state_reg == ICC_DISABLING && cnt_last && !cmd.req_en &&
     !cmd.req_soft_reset_status_flag) |=> (!capture_enable && disable_done_flag_reg))
    else $error("disable did not complete");
  dual_write_a : assert property (
    (cmd.req_en && take_cmd && reg_wdata[ICC_DIS_BIT])
    |=> (state_reg == ICC_IDLE && capture_enable))
    else $error("disable acted beside enable");
  soft_reset_status_flag_start_a : assert property (
    cmd.req_soft_reset_status_flag |=> (soft_reset && resetting && !capture_enable &&
                      !codec_enable))
    else $error("soft reset did not start");
  soft_reset_status_flag_end_a : assert property (
    (resetting && cnt_last && !cmd.req_soft_reset_status_flag)
    |=> (!soft_reset && state_reg == ICC_IDLE))
    else $error("soft reset did not end");
  codec_take_a : assert property (
    (cdc_accept && !frame_done) |=> codec_enable)
    else $error("codec request not taken");
  codec_ignore_a : assert property (
    (codec_pending_flag_reg && cmd.req_cdc && frame_done && !cmd.req_soft_reset_status_flag)
    |=> !codec_enable)
    else $error("codec request taken while pending");
  idle_stable_a : assert property (
    (state_reg == ICC_IDLE && !cmd.req_en && !cmd.req_dis &&
     !cmd.req_soft_reset_status_flag) |=> $stable(capture_enable))
    else $error("enable changed without a request");
  soft_reset_status_flag_drop_a : assert property (
    (resetting && !cmd.req_soft_reset_status_flag && (cmd.req_en || cmd.req_cdc))
    |=> (!capture_enable && !codec_enable))
    else $error("request taken during soft reset");
  disable_idle_a : assert property (
    (dis_start && !enabled_reg && !cmd.req_en) |=> disable_done_flag_reg)
    else $error("disable of idle module not done");
  codec_hold_a : assert property (
    (codec_enable && !frame_done && !cmd.req_soft_reset_status_flag) |=> codec_enable)
    else $error("codec pending dropped early");

  // ==================================================
  // covers
  codec_block_c : cover property (
    codec_pending_flag_reg && cmd.req_cdc);
  enable_seen_c : cover property (
    cmd.req_en ##1 capture_enable);
  disable_seen_c : cover property (
    $rose(state_reg == ICC_DISABLING) ##[1:20] disable_done_flag_reg);
  soft_reset_status_flag_seen_c : cover property (
    $rose(soft_reset) ##[1:20] $fell(soft_reset));
  codec_seen_c : cover property (
    $rose(codec_enable) ##[1:20] frame_done);
endmodule : icc_capture_ctrl

// ==== icc_cmd_decode.sv ====
// register port slave: command decode and status read-back
`timescale 1ns/100ps
module icc_cmd_decode (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [icc_pkg::ICC_ADDR_W-1:0] reg_addr,
  input wire logic [icc_pkg::ICC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [icc_pkg::ICC_DATA_W-1:0] reg_rdata,
  icc_cmd_if.decode cmd
);
  import icc_pkg::*;

  logic [ICC_DATA_W-1:0] rdata_reg;
  logic [ICC_DATA_W-1:0] rdata_next;
  logic [ICC_DATA_W-1:0] status_word;
  wire cmd_wr = reg_wr && (reg_addr == ICC_CMD_OFFSET);
  wire stat_rd = reg_rd && (reg_addr == ICC_STAT_OFFSET);

  // ==================================================
  // command decode
  // pulses, no state
  assign cmd.req_en = cmd_wr && reg_wdata[ICC_EN_BIT];
  assign cmd.req_dis = cmd_wr && reg_wdata[ICC_DIS_BIT] &&
                       !reg_wdata[ICC_EN_BIT];
  assign cmd.req_soft_reset_status_flag = cmd_wr && reg_wdata[ICC_SOFT_RESET_STATUS_FLAG_BIT];
  assign cmd.req_cdc = cmd_wr && reg_wdata[ICC_CDC_BIT];

  // ==================================================
  // status read-back
  always_comb begin
    status_word = ICC_READ_ZERO;
    status_word[ICC_ST_ENABLED_BIT] = cmd.st_enabled;
    status_word[ICC_ST_DISABLE_DONE_FLAG_BIT] = cmd.st_disable_done_flag;
    status_word[ICC_ST_SOFT_RESET_STATUS_FLAG_BIT] = cmd.st_soft_reset_status_flag;
    status_word[ICC_ST_CODEC_PENDING_FLAG_BIT] = cmd.st_codec_pending_flag;
  end
  assign rdata_next = stat_rd ? status_word : ICC_READ_ZERO;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= ICC_READ_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ==================================================
  // checks
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  both_bits_drop_a : assert property (
    (cmd_wr && reg_wdata[ICC_EN_BIT] && reg_wdata[ICC_DIS_BIT])
    |-> (cmd.req_en && !cmd.req_dis))
    else $error("disable taken alongside enable");
  zero_write_noop_a : assert property (
    (reg_wr && !cmd_wr) || (cmd_wr && reg_wdata == ICC_READ_ZERO)
    |-> !(cmd.req_en || cmd.req_dis || cmd.req_soft_reset_status_flag || cmd.req_cdc))
    else $error("request raised without a one written");
  cmd_read_zero_a : assert property (
    (reg_rd && reg_addr == ICC_CMD_OFFSET) |=> (reg_rdata == ICC_READ_ZERO))
    else $error("command register read back non-zero");
endmodule : icc_cmd_decode

// ==== icc_cmd_if.sv ====
// request pulses and status flags between decoder and sequencer
`timescale 1ns/100ps
interface icc_cmd_if;
  logic req_en;
  logic req_dis;
  logic req_soft_reset_status_flag;
  logic req_cdc;
  logic st_enabled;
  logic st_disable_done_flag;
  logic st_soft_reset_status_flag;
  logic st_codec_pending_flag;
  modport decode (
    output req_en,
    output req_dis,
    output req_soft_reset_status_flag,
    output req_cdc,
    input st_enabled,
    input st_disable_done_flag,
    input st_soft_reset_status_flag,
    input st_codec_pending_flag
  );
  modport seq (
    input req_en,
    input req_dis,
    input req_soft_reset_status_flag,
    input req_cdc,
    output st_enabled,
    output st_disable_done_flag,
    output st_soft_reset_status_flag,
    output st_codec_pending_flag
  );
endinterface : icc_cmd_if

// ==== icc_pkg.sv ====
// constants and types for the capture command controller
package icc_pkg;
  // ==================================================
  // register map
  localparam int ICC_ADDR_W = 8;
  localparam int ICC_DATA_W = 32;
  localparam logic [7:0] ICC_CMD_OFFSET = 8'h24;
  localparam logic [7:0] ICC_STAT_OFFSET = 8'h28;
  localparam logic [31:0] ICC_READ_ZERO = 32'h0000_0000;
  // ==================================================
  // command bit positions
  localparam int ICC_EN_BIT = 0;
  localparam int ICC_DIS_BIT = 1;
  localparam int ICC_SOFT_RESET_STATUS_FLAG_BIT = 2;
  localparam int ICC_CDC_BIT = 8;
  // ==================================================
  // status bit positions
  localparam int ICC_ST_ENABLED_BIT = 0;
  localparam int ICC_ST_DISABLE_DONE_FLAG_BIT = 1;
  localparam int ICC_ST_SOFT_RESET_STATUS_FLAG_BIT = 2;
  localparam int ICC_ST_CODEC_PENDING_FLAG_BIT = 8;
  // ==================================================
  // timing counts in clk_sys cycles
  localparam logic [7:0] ICC_DIS_CYCLES = 8'h04;
  localparam logic [7:0] ICC_SOFT_RESET_STATUS_FLAG_CYCLES = 8'h08;
  localparam logic [7:0] ICC_CNT_ONE = 8'h01;
  localparam logic [7:0] ICC_CNT_ZERO = 8'h00;
  // ==================================================
  // sequencer states
  typedef enum logic [1:0] {
    ICC_IDLE = 2'b00,
    ICC_DISABLING = 2'b01,
    ICC_RESETTING = 2'b10
  } icc_state_e;
endpackage : icc_pkg

// ==== tb.sv ====
// self-checking testbench for the capture command controller
`timescale 1ns/100ps
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("mismatch %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb;
  import icc_pkg::*;
  // ==================================================
  // shortened counts and bench signals
  localparam logic [7:0] P_DIS = 8'h03;
  localparam logic [7:0] P_SOFT_RESET_STATUS_FLAG = 8'h05;
  logic clk_sys;
  logic reset_n;
  logic [ICC_ADDR_W-1:0] reg_addr;
  logic [ICC_DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [ICC_DATA_W-1:0] reg_rdata;
  logic frame_done;
  logic capture_enable;
  logic codec_enable;
  logic soft_reset;
  logic rd_seen;
  logic [2:0] pin_snap;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  int n_errors;
  int total_checks;
  int seed;
  int i;
  logic [31:0] rnd;
  logic [7:0] a;
  icc_capture_ctrl #(
    .DIS_CYCLES(P_DIS),
    .SOFT_RESET_STATUS_FLAG_CYCLES(P_SOFT_RESET_STATUS_FLAG)
  ) i_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .frame_done(frame_done),
    .capture_enable(capture_enable),
    .codec_enable(codec_enable),
    .soft_reset(soft_reset)
  );
  // ==================================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  // ==================================================
  // helpers
  function automatic logic [31:0] st(logic en, logic dd, logic sr, logic cp);
    logic [31:0] w;
    w = ICC_READ_ZERO;
    w[ICC_ST_ENABLED_BIT] = en;
    w[ICC_ST_DISABLE_DONE_FLAG_BIT] = dd;
    w[ICC_ST_SOFT_RESET_STATUS_FLAG_BIT] = sr;
    w[ICC_ST_CODEC_PENDING_FLAG_BIT] = cp;
    return w;
  endfunction : st
  task automatic drv(logic w, logic r, logic [7:0] ad, logic [31:0] d,
                     logic fd);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= ad;
    reg_wdata <= d;
    frame_done <= fd;
  endtask : drv
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    drv(1'b1, 1'b0, ad, d, 1'b0);
  endtask : wr
  task automatic rd(logic [7:0] ad, logic s, logic [31:0] ex);
    exp_q.push_back({s, ex});
    drv(1'b0, 1'b1, ad, 32'h0000_0000, 1'b0);
  endtask : rd
  task automatic rds(logic [31:0] ex);
    rd(ICC_STAT_OFFSET, 1'b1, ex);
  endtask : rds
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // ==================================================
  // result monitor: read data and pins against oldest note
  always @(posedge clk_sys) begin
    rd_seen <= reg_rd;
    pin_snap <= {codec_enable, soft_reset, capture_enable};
  end
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK("note queue", 1'b1, 1'b0)
      end else begin
        note = exp_q.pop_front();
        `CHK("reg_rdata", note[31:0], reg_rdata)
        if (note[32]) begin
          `CHK("pins", {note[8], note[2], note[0]}, pin_snap)
        end
      end
    end
  end
  // ==================================================
  // stimulus
  initial begin
    seed = 30;
    n_errors = 0;
    total_checks = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_done = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rds(st(0, 0, 0, 0));
    rd(ICC_CMD_OFFSET, 1'b0, ICC_READ_ZERO);
    rd(8'h30, 1'b0, ICC_READ_ZERO);
    wr(ICC_CMD_OFFSET, 32'h0000_0000);
    rds(st(0, 0, 0, 0));
    wr(ICC_CMD_OFFSET, 32'h0000_0001);
    rds(st(1, 0, 0, 0));
    wr(ICC_CMD_OFFSET, 32'h0000_0002);
    for (i = 1; i <= P_DIS + 1; i++) begin
      rds(st(i <= P_DIS, i > P_DIS, 0, 0));
    end
    wr(ICC_CMD_OFFSET, 32'h0000_0003);
    for (i = 1; i <= P_DIS + 2; i++) begin
      rds(st(1, 0, 0, 0));
    end
    wr(ICC_CMD_OFFSET, 32'h0000_0100);
    rds(st(1, 0, 0, 1));
    drv(1'b1, 1'b0, ICC_CMD_OFFSET, 32'h0000_0100, 1'b1);
    rds(st(1, 0, 0, 0));
    wr(ICC_CMD_OFFSET, 32'h0000_0100);
    wr(ICC_CMD_OFFSET, 32'h0000_0107);
    wr(ICC_CMD_OFFSET, 32'h0000_0103);
    for (i = 2; i <= P_SOFT_RESET_STATUS_FLAG + 1; i++) begin
      rds(st(0, 0, i <= P_SOFT_RESET_STATUS_FLAG, 0));
    end
    wr(ICC_CMD_OFFSET, 32'h0000_0002);
    rds(st(0, 1, 0, 0));
    for (i = 0; i < 8; i++) begin
      rnd = $random(seed);
      a = rnd[7:0];
      if (a == ICC_CMD_OFFSET) a = ICC_STAT_OFFSET;
      wr(a, $random(seed));
      rnd = $random(seed);
      wr(ICC_CMD_OFFSET, rnd & 32'hFFFF_FEF8);
    end
    rds(st(0, 1, 0, 0));
    repeat (2) drv(1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b0);
    reset_n <= 1'b0;
    drv(1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b0);
    reset_n <= 1'b1;
    rds(st(0, 0, 0, 0));
    repeat (4) drv(1'b0, 1'b0, 8'h00, 32'h0000_0000, 1'b0);
    `CHK("notes left", 0, exp_q.size())
    close_out();
  end
endmodule : tb
